// ---- hdl/rss_seq.sv ----
// Reset and start-up sequencer with watchdog and I/O port decode
// Function
// - Power-on, watchdog and soft USB bus reset
// - Reset restores defaults, clears address, interrupts
// - Both stack pointers load zero on reset
// - Cause bits 4,5,6 in status register
// - Execution restarts at address zero
// - Reset entry pushes nothing onto stack
// - Power-on floats ports, samples wake pin
// - Wake high and idle bus enters suspend
// - Suspend exit with wake high waits 128us
// - Wake low after power-on waits 128ms
// - Delay: wake high short, else flag long
// - Port read to accumulator, write from it
// - Indexed write adds index to address
// - Watchdog MSB rise resets; writes clear it
// - Watchdog reset held 2.048 ms
`timescale 1ns/1ps
module rss_seq #(
    parameter int unsigned SHORT_CYCLES = rss_pkg::SHORT_CYC,
    parameter int unsigned LONG_CYCLES  = rss_pkg::LONG_CYC,
    parameter int unsigned WDR_CYCLES   = rss_pkg::WDR_CYC
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Pins and events
    input  wire logic       i_wake_sel,
    input  wire logic       i_usb_dm,
    input  wire logic       i_usb_dp,
    input  wire logic       i_usb_bus_reset,
    input  wire logic       i_wdt_tick,
    // Core I/O instructions
    input  wire logic       i_io_rd,
    input  wire logic       i_io_wr,
    input  wire logic       i_io_wx,
    input  wire logic [7:0] i_io_addr,
    input  wire logic [7:0] i_index_x,
    input  wire logic [7:0] i_acc,
    input  wire logic [7:0] i_port_rdata,
    // Core control
    output logic            o_core_reset,
    output logic            o_usb_addr_clear,
    output logic            o_gpio_hiz,
    output logic            o_suspend,
    // Port access
    output logic [7:0]      o_io_addr,
    output logic            o_io_wstb,
    output logic            o_io_rstb,
    output logic [7:0]      o_io_wdata,
    output logic            o_acc_load,
    output logic [7:0]      o_acc_data
);
    import rss_pkg::*;

    rss_tmr_if tif ();

    rss_timer u_timer (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .t        (tif.tmr)
    );

    rss_state_t state;
    rss_state_t next_state;
    logic [1:0] wdt;
    logic [1:0] next_wdt;
    logic [7:0] cause;
    logic [7:0] next_cause;
    logic       next_core_reset;
    logic       next_usb_addr_clear;
    logic       next_gpio_hiz;
    logic       next_suspend;
    logic [7:0] next_io_addr;
    logic       next_io_wstb;
    logic       next_io_rstb;
    logic [7:0] next_acc_data;
    logic       next_acc_load;
    logic [7:0] eff_addr;
    logic       run;
    logic       bus_idle;
    logic       wdt_fire;
    logic       usb_rst;
    logic [TW-1:0] startup_len;

    assign run      = (state == ST_RUN);
    assign bus_idle = i_usb_dm && !i_usb_dp;
    assign eff_addr = i_io_wx ? 8'(i_io_addr + i_index_x) : i_io_addr;
    assign usb_rst  = run && i_usb_bus_reset;
    assign startup_len = (!i_wake_sel && cause[BIT_POR]) ? TW'(LONG_CYCLES)
                                                         : TW'(SHORT_CYCLES);

    always_comb begin
        next_state = state;
        next_wdt   = wdt;
        next_cause = cause;
        wdt_fire   = 1'b0;
        tif.start  = 1'b0;
        tif.len    = startup_len;
        if (run && (i_io_wr || i_io_wx) && eff_addr == ADDR_WDT_CLR) begin
            next_wdt = WDT_RESET;
        end else if (run && i_wdt_tick) begin
            next_wdt = wdt + 2'h1;
            wdt_fire = !wdt[1] && next_wdt[1];
        end
        if (run && (i_io_wr || i_io_wx) && eff_addr == ADDR_PSC) begin
            next_cause = cause & i_acc & CAUSE_MASK;
        end
        if (usb_rst) begin
            next_cause[BIT_USBR] = 1'b1;
        end
        case (state)
            ST_POR: begin
                next_state = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                if (i_wake_sel && bus_idle) begin
                    next_state = ST_SUSPEND;
                end else begin
                    next_state = ST_STARTUP;
                    tif.start  = 1'b1;
                end
            end
            ST_SUSPEND: begin
                if (!bus_idle || i_usb_bus_reset) begin
                    next_state = ST_STARTUP;
                    tif.start  = 1'b1;
                end
            end
            ST_STARTUP: begin
                if (tif.done) begin
                    next_state = ST_RUN;
                end
            end
            ST_WDR: begin
                tif.len = TW'(WDR_CYCLES);
                if (tif.done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                if (wdt_fire) begin
                    next_state = ST_WDR;
                    tif.len    = TW'(WDR_CYCLES);
                    tif.start  = 1'b1;
                    next_wdt   = WDT_RESET;
                    next_cause[BIT_WDR] = 1'b1;
                end
            end
        endcase
        // core held in reset, no push
        next_core_reset     = (next_state != ST_RUN);
        next_usb_addr_clear = (next_state != ST_RUN) || usb_rst;
        next_gpio_hiz       = (next_state == ST_SAMPLE) || (next_state == ST_SUSPEND)
                              || (next_state == ST_STARTUP && cause[BIT_POR] && !run);
        next_suspend        = (next_state == ST_SUSPEND);
        next_io_addr  = eff_addr;
        next_io_wstb  = run && (i_io_wr || i_io_wx);
        next_io_rstb  = run && i_io_rd;
        next_acc_load = run && i_io_rd;
        next_acc_data = (eff_addr == ADDR_PSC) ? (cause & CAUSE_MASK) : i_port_rdata;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state            <= ST_POR;
            wdt              <= WDT_RESET;
            cause            <= PSC_POR_VAL;
            o_core_reset     <= 1'b1;
            o_usb_addr_clear <= 1'b1;
            o_gpio_hiz       <= 1'b1;
            o_suspend        <= 1'b0;
            o_io_addr        <= BYTE_ZERO;
            o_io_wstb        <= 1'b0;
            o_io_rstb        <= 1'b0;
            o_io_wdata       <= BYTE_ZERO;
            o_acc_load       <= 1'b0;
            o_acc_data       <= BYTE_ZERO;
        end else begin
            state            <= next_state;
            wdt              <= next_wdt;
            cause            <= next_cause;
            o_core_reset     <= next_core_reset;
            o_usb_addr_clear <= next_usb_addr_clear;
            o_gpio_hiz       <= next_gpio_hiz;
            o_suspend        <= next_suspend;
            o_io_addr        <= next_io_addr;
            o_io_wstb        <= next_io_wstb;
            o_io_rstb        <= next_io_rstb;
            o_io_wdata       <= i_acc;
            o_acc_load       <= next_acc_load;
            o_acc_data       <= next_acc_data;
        end
    end

    // Checks
    property p_por_cause;
        @(posedge i_clk) !i_resetn |=> cause[BIT_POR] && state == ST_POR;
    endproperty
    a_por_cause: assert property (p_por_cause) else $error("power-on cause not set");

    property p_wdt_fire;
        @(posedge i_clk) disable iff (!i_resetn)
        wdt_fire |=> state == ST_WDR && cause[BIT_WDR] ##1 o_core_reset;
    endproperty
    a_wdt_fire: assert property (p_wdt_fire) else $error("watchdog did not reset");

    property p_wdt_clear;
        @(posedge i_clk) disable iff (!i_resetn)
        run && i_io_wr && i_io_addr == ADDR_WDT_CLR |=> wdt == WDT_RESET;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

    property p_wdr_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        $rose(state == ST_WDR) |=> o_core_reset [*8];
    endproperty
    a_wdr_hold: assert property (p_wdr_hold) else $error("watchdog hold too short");

    // Same-cycle check: both flops load from next_state, so the core runs in the same cycle that state reaches ST_RUN
    property p_held;
        @(posedge i_clk) disable iff (!i_resetn)
        state != ST_RUN |-> o_core_reset && o_usb_addr_clear;
    endproperty
    a_held: assert property (p_held) else $error("core ran during reset");

    property p_suspend;
        @(posedge i_clk) disable iff (!i_resetn)
        state == ST_SAMPLE && i_wake_sel && bus_idle |=> state == ST_SUSPEND && o_suspend;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not entered");

    property p_wake_len;
        @(posedge i_clk) disable iff (!i_resetn)
        tif.start && state != ST_RUN && state != ST_WDR && !i_wake_sel && cause[BIT_POR]
        |-> tif.len == TW'(LONG_CYCLES);
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wrong start-up length");

    property p_indexed;
        @(posedge i_clk) disable iff (!i_resetn)
        run && i_io_wx |=> o_io_wstb && o_io_addr == 8'($past(i_io_addr) + $past(i_index_x));
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_read_psc;
        @(posedge i_clk) disable iff (!i_resetn)
        run && i_io_rd && i_io_addr == ADDR_PSC |=> o_acc_load && o_acc_data == $past(cause);
    endproperty
    a_read_psc: assert property (p_read_psc) else $error("status read wrong");

    property p_usb_soft;
        @(posedge i_clk) disable iff (!i_resetn)
        usb_rst && !wdt_fire |=> cause[BIT_USBR] && state == ST_RUN;
    endproperty
    a_usb_soft: assert property (p_usb_soft) else $error("bus reset mishandled");

    property p_tmr_live;
        @(posedge i_clk) disable iff (!i_resetn)
        state == ST_STARTUP || state == ST_WDR |-> tif.busy || tif.done;
    endproperty
    a_tmr_live: assert property (p_tmr_live) else $error("hold timer idle while holding");

    c_suspend: cover property (@(posedge i_clk) state == ST_SUSPEND ##1 state == ST_STARTUP);
    c_wdr:     cover property (@(posedge i_clk) state == ST_WDR ##1 state == ST_RUN);
    c_usb:     cover property (@(posedge i_clk) usb_rst);
endmodule

// ---- hdl/rss_pkg.sv ----
// Constants and types shared by the reset and start-up sequencer
package rss_pkg;
    localparam int unsigned CLK_MHZ     = 200;
    // Start-up and hold times in their own units
    localparam int unsigned SHORT_US    = 128;
    localparam int unsigned LONG_MS     = 128;
    localparam int unsigned WDR_HOLD_US = 2048;
    localparam int unsigned SHORT_CYC   = SHORT_US * CLK_MHZ;
    localparam int unsigned LONG_CYC    = LONG_MS * 1000 * CLK_MHZ;
    localparam int unsigned WDR_CYC     = WDR_HOLD_US * CLK_MHZ;
    localparam int unsigned TW          = 25;
    // I/O addresses
    localparam logic [7:0]  ADDR_WDT_CLR = 8'h26;
    localparam logic [7:0]  ADDR_PSC     = 8'hFF;
    // Cause bits of the processor status and control register
    localparam int unsigned BIT_POR      = 4;
    localparam int unsigned BIT_USBR     = 5;
    localparam int unsigned BIT_WDR      = 6;
    localparam logic [7:0]  CAUSE_MASK   = 8'h70;
    localparam logic [7:0]  PSC_POR_VAL  = 8'h10;
    localparam logic [1:0]  WDT_RESET    = 2'h0;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;

    typedef enum logic [2:0] {
        ST_POR, ST_SAMPLE, ST_SUSPEND, ST_STARTUP, ST_WDR, ST_RUN
    } rss_state_t;
endpackage

// ---- hdl/rss_tmr_if.sv ----
// Carrier between the sequencer and its hold timer
`timescale 1ns/1ps
interface rss_tmr_if;
    import rss_pkg::*;
    logic          start;
    logic [TW-1:0] len;
    logic          busy;
    logic          done;
    modport ctrl (output start, output len, input busy, input done);
    modport tmr  (input start, input len, output busy, output done);
endinterface

// ---- hdl/rss_timer.sv ----
// Down-counting hold timer for start-up and watchdog hold
`timescale 1ns/1ps
module rss_timer (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    // Control
    rss_tmr_if.tmr     t
);
    import rss_pkg::*;

    logic [TW-1:0] cnt;
    logic [TW-1:0] next_cnt;
    logic          busy;
    logic          next_busy;
    logic          done;
    logic          next_done;

    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (t.start) begin
            next_cnt  = t.len - TW'(1);
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt == '0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - TW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign t.busy = busy;
    assign t.done = done;
endmodule

// ---- test/rss_usb_model.sv ----
// USB bus model driving line states and the bus reset event
`timescale 1ns/1ps
module rss_usb_model (
    // Clock
    input  wire logic       i_clk,
    // Requested state: 0 idle, 1 K, 2 SE0, 3 bus reset
    input  wire logic [1:0] i_mode,
    // Bus side
    output logic            o_dm,
    output logic            o_dp,
    output logic            o_bus_reset
);
    // idle is DM high, DP low
    always_ff @(posedge i_clk) begin
        o_dm        <= (i_mode == 2'h0);
        o_dp        <= (i_mode == 2'h1);
        o_bus_reset <= (i_mode == 2'h3);
    end
endmodule

// ---- test/rss_seq_tb.sv ----
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module rss_seq_tb;
    import rss_pkg::*;
    localparam int unsigned SC = 20;
    localparam int unsigned LC = 50;
    localparam int unsigned WC = 30;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       wake = 1'b0;
    logic       wdt = 1'b0;
    logic       rd = 1'b0;
    logic       wr = 1'b0;
    logic       wx = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] x = 8'h00;
    logic [7:0] acc = 8'h00;
    logic [7:0] prd = 8'hA5;
    logic       dm, dp, brst, core_reset, addr_clear, hiz, susp;
    logic       wstb, rstb, ld, seen, held;
    logic [7:0] io_addr, wdata, adata;
    int         errors = 0;
    int         checks = 0;
    int         n;

    always #2.5 clk = ~clk;

    rss_usb_model rss_usb_model_i (.i_clk(clk), .i_mode(mode), .o_dm(dm), .o_dp(dp),
        .o_bus_reset(brst));

    rss_seq #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC), .WDR_CYCLES(WC)) rss_seq_i (
        .i_clk(clk), .i_resetn(resetn), .i_wake_sel(wake), .i_usb_dm(dm), .i_usb_dp(dp),
        .i_usb_bus_reset(brst), .i_wdt_tick(wdt), .i_io_rd(rd), .i_io_wr(wr),
        .i_io_wx(wx), .i_io_addr(addr), .i_index_x(x), .i_acc(acc), .i_port_rdata(prd),
        .o_core_reset(core_reset), .o_usb_addr_clear(addr_clear), .o_gpio_hiz(hiz),
        .o_suspend(susp), .o_io_addr(io_addr), .o_io_wstb(wstb), .o_io_rstb(rstb),
        .o_io_wdata(wdata), .o_acc_load(ld), .o_acc_data(adata));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Counts edges until the core is let go; bounded
    task automatic wait_run(output int cnt);
        cnt = 0;
        while (core_reset !== 1'b0 && cnt < 2000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    task automatic io(input logic [2:0] kind, input logic [7:0] a, input logic [7:0] xv,
                      input logic [7:0] av);
        @(posedge clk);
        rd <= kind[0];
        wr <= kind[1];
        wx <= kind[2];
        addr <= a;
        x <= xv;
        acc <= av;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        wx <= 1'b0;
        #1;
    endtask

    task automatic rdexp(input logic [7:0] a, input logic [7:0] eld, input logic [7:0] d);
        io(3'h1, a, 8'h00, 8'h00);
        chk("acc_load", eld, {7'h0, ld});
        chk("io_rstb", eld, {7'h0, rstb});
        if (eld == 8'h01)
            chk("acc_data", d, adata);
    endtask

    task automatic wrexp(input logic [2:0] k, input logic [7:0] a, input logic [7:0] xv,
                         input logic [7:0] av, input logic [7:0] ea);
        io(k, a, xv, av);
        chk("io_wstb", 8'h01, {7'h0, wstb});
        chk("io_addr", ea, io_addr);
        chk("io_wdata", av, wdata);
    endtask

    task automatic tick;
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        #1;
    endtask

    initial begin
        cyc(1);
        chk("core_reset", 8'h01, {7'h0, core_reset});
        chk("usb_addr_clear", 8'h01, {7'h0, addr_clear});
        chk("gpio_hiz", 8'h01, {7'h0, hiz});
        @(posedge clk);
        resetn <= 1'b1;
        #1;
        wait_run(n);
        chk("long_startup", 8'h01, {7'h0, n >= LC && n <= LC + 6});
        $display("test power_on done");
        rdexp(ADDR_PSC, 8'h01, PSC_POR_VAL);
        rdexp(8'h03, 8'h01, 8'hA5);
        wrexp(3'h2, 8'h30, 8'h00, 8'h5A, 8'h30);
        wrexp(3'h4, 8'h00, 8'h26, 8'h3C, 8'h26);
        wrexp(3'h4, 8'hF0, 8'h20, 8'hC3, 8'h10);
        // Flag cleared as firmware does before suspend
        wrexp(3'h2, ADDR_PSC, 8'h00, 8'h00, ADDR_PSC);
        rdexp(ADDR_PSC, 8'h01, 8'h00);
        $display("test io done");
        @(posedge clk);
        mode <= 2'h3;
        @(posedge clk);
        mode <= 2'h0;
        seen = 1'b0;
        held = 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1;
            seen |= addr_clear;
            held |= core_reset;
        end
        chk("usb_addr_clear", 8'h01, {7'h0, seen});
        chk("usb_core_reset", 8'h00, {7'h0, held});
        rdexp(ADDR_PSC, 8'h01, 8'h20);
        $display("test usb_reset done");
        tick();
        wrexp(3'h2, ADDR_WDT_CLR, 8'h00, 8'h00, ADDR_WDT_CLR);
        tick();
        cyc(3);
        chk("wdt_one_tick", 8'h00, {7'h0, core_reset});
        tick();
        cyc(3);
        chk("wdt_reset", 8'h01, {7'h0, core_reset});
        chk("wdt_addr_clear", 8'h01, {7'h0, addr_clear});
        wait_run(n);
        chk("wdt_hold", 8'h01, {7'h0, n >= WC - 4 && n <= WC + SC + 8});
        rdexp(ADDR_PSC, 8'h01, 8'h60);
        $display("test watchdog done");
        @(posedge clk);
        wake <= 1'b1;
        resetn <= 1'b0;
        cyc(2);
        @(posedge clk);
        resetn <= 1'b1;
        cyc(LC + 10);
        chk("suspend", 8'h01, {7'h0, susp});
        chk("suspend_held", 8'h01, {7'h0, core_reset});
        // Strobes while held must be ignored
        rdexp(ADDR_PSC, 8'h00, 8'h00);
        @(posedge clk);
        mode <= 2'h1;
        #1;
        wait_run(n);
        chk("short_startup", 8'h01, {7'h0, n >= SC && n <= SC + 8});
        chk("suspend_left", 8'h00, {7'h0, susp});
        rdexp(ADDR_PSC, 8'h01, PSC_POR_VAL);
        $display("test suspend done");
        // Parked again, woken by SE0 with the strap low
        @(posedge clk);
        mode <= 2'h0;
        resetn <= 1'b0;
        cyc(2);
        @(posedge clk);
        resetn <= 1'b1;
        cyc(4);
        chk("se0_suspend", 8'h01, {7'h0, susp});
        chk("suspend_hiz", 8'h01, {7'h0, hiz});
        @(posedge clk);
        wake <= 1'b0;
        mode <= 2'h2;
        #1;
        wait_run(n);
        chk("se0_long_startup", 8'h01, {7'h0, n >= LC && n <= LC + 6});
        chk("run_hiz", 8'h00, {7'h0, hiz});
        $display("test se0_wake done");
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #10000;
        errors++;
        close_out();
    end
endmodule
